/* File: hw/rsm_pkg.sv */
/*
 * Shared constants and types for the reconfiguration watch unit: register
 * offsets and bit positions, reset values, step timing and monitor states.
 * Assumes a 125 MHz system clock and 32-bit AHB-Lite register access.
 */
package rsm_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h0C;
    localparam logic [7:0] ALARM_CLR_OFS = 8'h10;

    // Control register fields
    localparam int CTRL_LOCK_POS  = 0;   // One lock bit per monitor instance, bits 0..3
    localparam int CTRL_VIAB_POS  = 4;   // Minimum viable configuration check enable
    localparam int CTRL_MAINS_POS = 5;   // 1: step from mains pin, 0: internal divider
    localparam int CTRL_W         = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // Interrupt status / mask fields
    localparam int IRQ_ALARM_POS = 0;
    localparam int IRQ_TOUT_POS  = 1;
    localparam int IRQ_EARLY_POS = 2;
    localparam int IRQ_W         = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Status word: one byte per instance
    localparam int STAT_LANE_W    = 8;
    localparam int STAT_CNT_W     = 5;
    localparam int STAT_RUN_POS   = 5;
    localparam int STAT_TOUT_POS  = 6;
    localparam int STAT_ALARM_POS = 7;

    // Timeout counter and step timing
    localparam int CNT_W_DEF     = 5;      // 32 step periods when no extra enable
    localparam int TMO_STEPS     = 32;
    localparam int STEP_MS       = 16;     // One counter step
    localparam int CLK_HZ        = 125_000_000;
    localparam int STEP_CYCLES_DEF = STEP_MS * (CLK_HZ / 1000);
    localparam int MIN_VIABLE_CPUS = 2;
    localparam int N_CPU           = 4;
    localparam int N_MON_DEF       = 2;

    typedef enum logic [1:0] {
        RSM_IDLE,
        RSM_RUN,
        RSM_TOUT
    } rsm_state_t;

    // Captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } rsm_ahb_req_t;

endpackage

/* File: hw/rsm_reconfig_watch_unit.sv */
/*
 * Reconfiguration watch unit: duplexed hardware watchdog supervising the
 * reconfiguration state of four processors, with AHB-Lite register access.
 * Assumes all pin inputs are asynchronous and that the bus is single-slave
 * with whole-word single transfers.
 */
// Register access over AHB-Lite and the address map were left to the implementer.
//
// Contract
// - First enable while idle starts the timeout counter and opens a period.
// - Each further enable in a period forces the next high counter bit on.
// - Period is 32 steps, then 16, 8, 4 with one to three extra enables.
// - Counter steps on a 16 ms mains-derived pulse: 512 ms to 64 ms.
// - Each processor's reconfiguration-state line is watched against the period.
// - Alarm if reconfiguration state is not entered or not left before expiry.
// - End of reconfiguration state forces end carry, monitor ready at once.
// - Alarm goes to remote station and as interrupt to all processors.
// - Alarm clears only by remote/local reset pin or data-bus link write.
// - Remote alert stays on even if processors ignore the interrupt.
// - Raised alarm holds until reset, whatever the state lines do.
// - Two independent monitor instances; either one alone raises the alarm.
// - Each instance can be locked into alarm separately for testing the other.
`timescale 1ns/1ns
module rsm_reconfig_watch_unit #(
    parameter int N_MON       = rsm_pkg::N_MON_DEF,
    parameter int CNT_W       = rsm_pkg::CNT_W_DEF,
    parameter int STEP_CYCLES = rsm_pkg::STEP_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                      CLK_I,
    input  wire logic                      RST_N_I,
    // AHB-Lite slave
    input  wire logic                      HSEL_I,
    input  wire logic [31:0]               HADDR_I,
    input  wire logic [1:0]                HTRANS_I,
    input  wire logic                      HWRITE_I,
    input  wire logic [2:0]                HSIZE_I,
    input  wire logic [31:0]               HWDATA_I,
    input  wire logic                      HREADY_I,
    output logic      [31:0]               HRDATA_O,
    output logic                           HREADYOUT_O,
    output logic                           HRESP_O,
    // Processor lines
    input  wire logic [rsm_pkg::N_CPU-1:0] ENABLE_I,
    input  wire logic [rsm_pkg::N_CPU-1:0] STATE3_I,
    input  wire logic [rsm_pkg::N_CPU-1:0] OPERATIONAL_I,
    // External resets and mains step
    input  wire logic                      ALARM_RESET_I,
    input  wire logic                      TIMEOUT_RESET_I,
    input  wire logic                      MAINS_STEP_I,
    // Alarm and status outputs
    output logic                           REMOTE_ALERT_OUT_O,
    output logic                           ALARM_IRQ_CPU_O,
    output logic                           TIMEOUT_OCCURRED_O,
    output logic                           IRQ_O
);

    localparam int SYNC_W = 3 * rsm_pkg::N_CPU + 3;
    localparam int DIV_W  = $clog2(STEP_CYCLES);

    generate
        if (N_MON < 1 || N_MON > 4 || CNT_W < 3 || CNT_W > rsm_pkg::STAT_CNT_W || STEP_CYCLES < 2) begin : g_chk
            $error("rsm_reconfig_watch_unit: unsupported parameter value");
        end
    endgenerate

    // Two-stage synchronisers for every pin input
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [rsm_pkg::N_CPU-1:0] en_prev_q;
    logic                      mains_prev_q;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {MAINS_STEP_I, TIMEOUT_RESET_I, ALARM_RESET_I, OPERATIONAL_I, STATE3_I, ENABLE_I};
            sync2_q <= sync1_q;
        end
    end

    logic [rsm_pkg::N_CPU-1:0] en_s;
    logic [rsm_pkg::N_CPU-1:0] s3_s;
    logic [rsm_pkg::N_CPU-1:0] oper_s;
    logic                      alarm_rst_s;
    logic                      tmo_rst_s;
    logic                      mains_s;

    assign {mains_s, tmo_rst_s, alarm_rst_s, oper_s, s3_s, en_s} = sync2_q;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            en_prev_q    <= '0;
            mains_prev_q <= 1'b0;
        end else begin
            en_prev_q    <= en_s;
            mains_prev_q <= mains_s;
        end
    end

    logic en_pulse;
    logic s3_any;
    logic below_viable;

    assign en_pulse     = |(en_s & ~en_prev_q);
    assign s3_any       = |s3_s;
    assign below_viable = $countones(oper_s) < rsm_pkg::MIN_VIABLE_CPUS;

    // Registers
    logic [rsm_pkg::CTRL_W-1:0] ctrl_q;
    logic [rsm_pkg::IRQ_W-1:0]  irq_stat_q;
    logic [rsm_pkg::IRQ_W-1:0]  irq_mask_q;

    // Step pulse: internal divider or synchronised mains edge
    logic [DIV_W-1:0] div_q;
    logic             div_tick_q;
    logic             step;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            div_q      <= '0;
            div_tick_q <= 1'b0;
        end else if (div_q == DIV_W'(STEP_CYCLES - 1)) begin
            div_q      <= '0;
            div_tick_q <= 1'b1;
        end else begin
            div_q      <= div_q + 1'b1;
            div_tick_q <= 1'b0;
        end
    end

    assign step = ctrl_q[rsm_pkg::CTRL_MAINS_POS] ? (mains_s & ~mains_prev_q) : div_tick_q;

    // Monitor instances
    rsm_pkg::rsm_state_t  st_q    [N_MON];
    logic [CNT_W-1:0]     cnt_q   [N_MON];
    logic [CNT_W-1:0]     pmask_q [N_MON];
    logic [N_MON-1:0]     seen_q;
    logic [N_MON-1:0]     alarm_q;
    logic [N_MON-1:0]     expire_w;
    logic [N_MON-1:0]     early_w;
    logic [N_MON-1:0]     set_w;
    logic                 alarm_clr;

    genvar gi;
    generate
        for (gi = 0; gi < N_MON; gi++) begin : g_mon
            logic forced;
            logic viab_fail;

            assign forced    = (st_q[gi] == rsm_pkg::RSM_RUN) && seen_q[gi] && !s3_any;
            assign expire_w[gi] = (st_q[gi] == rsm_pkg::RSM_RUN) && !forced && step && (&cnt_q[gi]);
            assign early_w[gi]  = forced;
            assign viab_fail = ctrl_q[rsm_pkg::CTRL_VIAB_POS] && below_viable && (forced || expire_w[gi]);
            // Expiry means state 3 never came or never ended
            assign set_w[gi] = expire_w[gi] || viab_fail;

            always_ff @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    st_q[gi]    <= rsm_pkg::RSM_IDLE;
                    cnt_q[gi]   <= '0;
                    pmask_q[gi] <= '0;
                    seen_q[gi]  <= 1'b0;
                end else begin
                    case (st_q[gi])
                        rsm_pkg::RSM_IDLE: begin
                            if (en_pulse) begin
                                st_q[gi]    <= rsm_pkg::RSM_RUN;
                                cnt_q[gi]   <= '0;
                                pmask_q[gi] <= {1'b1, {(CNT_W-1){1'b0}}};
                                seen_q[gi]  <= 1'b0;
                            end
                        end
                        rsm_pkg::RSM_RUN: begin
                            if (forced) begin
                                st_q[gi]    <= rsm_pkg::RSM_IDLE;
                                cnt_q[gi]   <= '0;
                                pmask_q[gi] <= '0;
                            end else if (expire_w[gi]) begin
                                st_q[gi]    <= rsm_pkg::RSM_TOUT;
                                cnt_q[gi]   <= '0;
                                pmask_q[gi] <= '0;
                            end else begin
                                // Preset bit rides on top of any step in the same cycle
                                cnt_q[gi]   <= (step ? cnt_q[gi] + 1'b1 : cnt_q[gi])
                                               | (en_pulse ? pmask_q[gi] : '0);
                                if (en_pulse) begin
                                    pmask_q[gi] <= pmask_q[gi] >> 1;
                                end
                                seen_q[gi]  <= seen_q[gi] | s3_any;
                            end
                        end
                        rsm_pkg::RSM_TOUT: begin
                            if (tmo_rst_s) begin
                                st_q[gi] <= rsm_pkg::RSM_IDLE;
                            end
                        end
                        default: begin
                            st_q[gi] <= rsm_pkg::RSM_IDLE;
                        end
                    endcase
                end
            end

            // Lock and new alarm win over any clear; state lines cannot clear it
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    alarm_q[gi] <= 1'b0;
                end else begin
                    alarm_q[gi] <= set_w[gi] || ctrl_q[rsm_pkg::CTRL_LOCK_POS + gi]
                                   || (alarm_q[gi] && !alarm_clr);
                end
            end
        end
    endgenerate

    // AHB-Lite slave: zero wait state, always OKAY
    rsm_pkg::rsm_ahb_req_t req_q;
    logic                  take;
    logic [31:0]           status_w;
    logic [31:0]           rdata_d;

    assign take = HSEL_I && HTRANS_I[1] && HREADY_I;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            req_q       <= '0;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            HRDATA_O    <= '0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            if (HREADY_I) begin
                req_q.valid <= take;
                req_q.write <= HWRITE_I;
                req_q.addr  <= HADDR_I[7:0];
                HRDATA_O    <= (take && !HWRITE_I) ? rdata_d : '0;
            end
        end
    end

    always_comb begin
        status_w = '0;
        for (int i = 0; i < N_MON; i++) begin
            status_w[i*rsm_pkg::STAT_LANE_W +: rsm_pkg::STAT_CNT_W] = rsm_pkg::STAT_CNT_W'(cnt_q[i]);
            status_w[i*rsm_pkg::STAT_LANE_W + rsm_pkg::STAT_RUN_POS]   = (st_q[i] == rsm_pkg::RSM_RUN);
            status_w[i*rsm_pkg::STAT_LANE_W + rsm_pkg::STAT_TOUT_POS]  = (st_q[i] == rsm_pkg::RSM_TOUT);
            status_w[i*rsm_pkg::STAT_LANE_W + rsm_pkg::STAT_ALARM_POS] = alarm_q[i];
        end
    end

    always_comb begin
        case (HADDR_I[7:0])
            rsm_pkg::CTRL_OFS:     rdata_d = 32'(ctrl_q);
            rsm_pkg::STATUS_OFS:   rdata_d = status_w;
            rsm_pkg::IRQ_STAT_OFS: rdata_d = 32'(irq_stat_q);
            rsm_pkg::IRQ_MASK_OFS: rdata_d = 32'(irq_mask_q);
            default:               rdata_d = 32'h0000_0000;
        endcase
    end

    logic wr;
    assign wr        = req_q.valid && req_q.write;
    // Data-bus link write is the processors' only way to clear the alarm
    assign alarm_clr = alarm_rst_s || (wr && req_q.addr == rsm_pkg::ALARM_CLR_OFS && HWDATA_I[0]);

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ctrl_q     <= rsm_pkg::CTRL_RST;
            irq_mask_q <= rsm_pkg::IRQ_MASK_RST;
        end else if (wr) begin
            if (req_q.addr == rsm_pkg::CTRL_OFS) begin
                ctrl_q <= HWDATA_I[rsm_pkg::CTRL_W-1:0];
            end
            if (req_q.addr == rsm_pkg::IRQ_MASK_OFS) begin
                irq_mask_q <= HWDATA_I[rsm_pkg::IRQ_W-1:0];
            end
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear
    logic [rsm_pkg::IRQ_W-1:0] irq_ev;
    logic [rsm_pkg::IRQ_W-1:0] irq_w1c;

    always_comb begin
        irq_ev = '0;
        irq_ev[rsm_pkg::IRQ_ALARM_POS] = |(set_w & ~alarm_q);
        irq_ev[rsm_pkg::IRQ_TOUT_POS]  = |expire_w;
        irq_ev[rsm_pkg::IRQ_EARLY_POS] = |early_w;
    end

    assign irq_w1c = (wr && req_q.addr == rsm_pkg::IRQ_STAT_OFS) ? HWDATA_I[rsm_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_ev | (irq_stat_q & ~irq_w1c);
        end
    end

    // Outputs
    logic tout_any;
    always_comb begin
        tout_any = 1'b0;
        for (int i = 0; i < N_MON; i++) begin
            tout_any = tout_any | (st_q[i] == rsm_pkg::RSM_TOUT);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            REMOTE_ALERT_OUT_O <= 1'b0;
            ALARM_IRQ_CPU_O    <= 1'b0;
            TIMEOUT_OCCURRED_O <= 1'b0;
            IRQ_O              <= 1'b0;
        end else begin
            // Remote alert ignores the processor-side mask entirely
            REMOTE_ALERT_OUT_O <= |alarm_q;
            ALARM_IRQ_CPU_O    <= |alarm_q;
            TIMEOUT_OCCURRED_O <= tout_any;
            IRQ_O              <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule

/* File: testbench/rsm_watch_properties.sv */
/* Checker of the watch unit top ports: bus answer, alarm, timeout and lock.
   Assumes one clock and the synchronous active-low reset of the top. */
`timescale 1ns/1ns
module rsm_watch_properties (
    // Bus
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    // Pins
    input wire logic        ALARM_RESET_I,
    input wire logic        TIMEOUT_RESET_I,
    input wire logic        REMOTE_ALERT_OUT_O,
    input wire logic        ALARM_IRQ_CPU_O,
    input wire logic        TIMEOUT_OCCURRED_O,
    input wire logic        IRQ_O
);
    default clocking dck @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic       take;
    logic [3:0] clr_age_q;
    assign take = HSEL_I && HTRANS_I[1] && HREADY_I;
    // Only a recent clear request may let the alarm fall
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || ALARM_RESET_I || (take && HWRITE_I && HADDR_I[7:0] == rsm_pkg::ALARM_CLR_OFS)) begin
            clr_age_q <= 4'h0;
        end else if (clr_age_q != 4'hF) begin
            clr_age_q <= clr_age_q + 4'h1;
        end
    end
    property p_ready; HREADYOUT_O && !HRESP_O; endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or error response");
    property p_rd_idle; !(take && !HWRITE_I) |=> HRDATA_O == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read data phase");
    property p_both_paths; REMOTE_ALERT_OUT_O == ALARM_IRQ_CPU_O; endproperty
    a_both_paths: assert property (p_both_paths) else $error("remote alert and cpu alarm differ");
    property p_alarm_sticky; $fell(REMOTE_ALERT_OUT_O) |-> clr_age_q <= 4'h6; endproperty
    a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm fell without a clear");
    property p_tout_alarm; $rose(TIMEOUT_OCCURRED_O) |-> ##[0:2] REMOTE_ALERT_OUT_O; endproperty
    a_tout_alarm: assert property (p_tout_alarm) else $error("expiry without alarm");
    property p_tout_hold;
        TIMEOUT_OCCURRED_O && !TIMEOUT_RESET_I && !$past(TIMEOUT_RESET_I) && !$past(TIMEOUT_RESET_I, 2)
            && !$past(TIMEOUT_RESET_I, 3) |=> TIMEOUT_OCCURRED_O;
    endproperty
    a_tout_hold: assert property (p_tout_hold) else $error("timeout status dropped by itself");
    property p_tout_clear; TIMEOUT_RESET_I [*6] |-> !TIMEOUT_OCCURRED_O; endproperty
    a_tout_clear: assert property (p_tout_clear) else $error("timeout reset ignored");
    property p_lock_alarm;
        take && HWRITE_I && HADDR_I[7:0] == rsm_pkg::CTRL_OFS ##1 HWDATA_I[rsm_pkg::CTRL_LOCK_POS]
            |-> ##[1:3] REMOTE_ALERT_OUT_O;
    endproperty
    a_lock_alarm: assert property (p_lock_alarm) else $error("lock did not raise alarm");
    c_alarm: cover property ($rose(REMOTE_ALERT_OUT_O));
    c_tout: cover property ($rose(TIMEOUT_OCCURRED_O));
    c_irq: cover property ($rose(IRQ_O));
endmodule
bind rsm_reconfig_watch_unit rsm_watch_properties i_rsm_watch_properties (.CLK_I, .RST_N_I, .HSEL_I, .HADDR_I,
    .HTRANS_I, .HWRITE_I, .HWDATA_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .ALARM_RESET_I,
    .TIMEOUT_RESET_I, .REMOTE_ALERT_OUT_O, .ALARM_IRQ_CPU_O, .TIMEOUT_OCCURRED_O, .IRQ_O);

/* File: testbench/rsm_cpu_model.sv */
/* Model of the four processors: enable, reconfiguration-state and operational lines.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ns
module rsm_cpu_model (
    // Clock
    input  wire logic       clk_i,
    // Processor lines
    output logic      [3:0] enable_o,
    output logic      [3:0] state3_o,
    output logic      [3:0] oper_o
);
    initial begin
        enable_o = 4'h0;
        state3_o = 4'h0;
        oper_o   = 4'hF;
    end
    // Held four cycles so the input synchronisers always see it
    task automatic enable_pulse(input int cpu);
        enable_o[cpu] <= 1'b1;
        repeat (4) @(posedge clk_i);
        enable_o[cpu] <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic set_lines(input logic [3:0] s3, input logic [3:0] op);
        state3_o <= s3;
        oper_o   <= op;
        @(posedge clk_i);
    endtask
endmodule

/* File: testbench/rsm_reconfig_watch_unit_test.sv */
/* Bench for the watch unit: AHB-Lite master, processor model, pin drivers and a
   watcher fed by an expectation queue. Assumes a short step divider. */
`timescale 1ns/1ns
module rsm_reconfig_watch_unit_test;
    localparam int STEP = 16;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] msk;
    } rsm_exp_t;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, atr = 1'b0, ttr = 1'b0, mains = 1'b0;
    logic        hready, hresp, remote, irq_cpu, tout, irq, dp_rd = 1'b0, snap = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [3:0]  en, s3, op;
    logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    int          errors = 0, cmp_count = 0, cyc = 0;
    rsm_exp_t    exp_q[$];
    always #4 clk = ~clk;
    rsm_cpu_model i_rsm_cpu_model (.clk_i(clk), .enable_o(en), .state3_o(s3), .oper_o(op));
    rsm_reconfig_watch_unit #(.STEP_CYCLES(STEP)) i_rsm_reconfig_watch_unit (.CLK_I(clk), .RST_N_I(rst_n),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .ENABLE_I(en),
        .STATE3_I(s3), .OPERATIONAL_I(op), .ALARM_RESET_I(atr), .TIMEOUT_RESET_I(ttr), .MAINS_STEP_I(mains),
        .REMOTE_ALERT_OUT_O(remote), .ALARM_IRQ_CPU_O(irq_cpu), .TIMEOUT_OCCURRED_O(tout), .IRQ_O(irq));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic compare(input logic [31:0] got);
        rsm_exp_t e;
        e.val = 32'hDEAD;
        e.msk = 32'hFFFFFFFF;
        if (exp_q.size() > 0) e = exp_q.pop_front();
        cmp_count++;
        if ((got & e.msk) !== (e.val & e.msk)) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e.val, got);
        end
    endtask
    always @(posedge clk) begin
        if (dp_rd) compare(hrdata);
        if (snap) compare({28'h0, remote, irq_cpu, tout, irq});
        dp_rd <= hsel && htrans[1] && hready && !hwrite;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            conclude();
        end
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back('{v, m});
        bus(1'b0, a, 32'h0);
    endtask
    // Order of the pin word: remote, cpu alarm, timeout, irq
    task automatic pins(input logic [3:0] v);
        exp_q.push_back('{{28'h0, v}, 32'hF});
        snap <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reset_pin(input bit t);
        if (t) ttr <= 1'b1;
        else atr <= 1'b1;
        repeat (8) @(posedge clk);
        ttr <= 1'b0;
        atr <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Held four cycles so the input synchronisers always see the edge
    task automatic mains_pulse();
        mains <= 1'b1;
        repeat (4) @(posedge clk);
        mains <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        int k, t0, n;
        void'($urandom(32'h4E96));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) rd(offs[i], 32'h0, 32'hFFFFFFFF);
        for (k = 0; k < 4; k++) begin
            t0 = cyc;
            n = (32 >> k) * STEP;
            i_rsm_cpu_model.enable_pulse($urandom_range(3));
            repeat (k) i_rsm_cpu_model.enable_pulse($urandom_range(3));
            while (tout !== 1'b1 && cyc - t0 < 700) @(posedge clk);
            cmp_count++;
            if (cyc - t0 < n - 12 || cyc - t0 > n + 12) begin
                errors++;
                $display("[ERR] t=%0t exp=%h got=%h", $time, n, cyc - t0);
            end
            repeat (3) @(posedge clk);
            if (k == 3) i_rsm_cpu_model.set_lines(4'h5, 4'hF);
            i_rsm_cpu_model.set_lines(4'h0, 4'hF);
            pins(4'hE);
            rd(rsm_pkg::STATUS_OFS, 32'h0000C0C0, 32'h0000E0E0);
            rd(rsm_pkg::IRQ_STAT_OFS, 32'h3, 32'h7);
            bus(1'b1, rsm_pkg::IRQ_MASK_OFS, 32'h1);
            repeat (2) @(posedge clk);
            pins(4'hF);
            bus(1'b1, rsm_pkg::IRQ_STAT_OFS, 32'h7);
            bus(1'b1, rsm_pkg::IRQ_MASK_OFS, 32'h0);
            rd(rsm_pkg::IRQ_STAT_OFS, 32'h0, 32'h7);
            reset_pin(1'b1);
            if (k[0]) bus(1'b1, rsm_pkg::ALARM_CLR_OFS, 32'h1);
            else reset_pin(1'b0);
            repeat (6) @(posedge clk);
            pins(4'h0);
        end
        i_rsm_cpu_model.enable_pulse($urandom_range(3));
        i_rsm_cpu_model.set_lines(4'h1 << $urandom_range(3), 4'hF);
        repeat (20) @(posedge clk);
        i_rsm_cpu_model.set_lines(4'h0, 4'hF);
        repeat (40 * STEP) @(posedge clk);
        pins(4'h0);
        rd(rsm_pkg::IRQ_STAT_OFS, 32'h4, 32'h7);
        rd(rsm_pkg::STATUS_OFS, 32'h0, 32'h0000E0E0);
        // Mains pin as step source: three presets leave four steps to expiry
        bus(1'b1, rsm_pkg::CTRL_OFS, 32'h20);
        repeat (4) i_rsm_cpu_model.enable_pulse($urandom_range(3));
        repeat (3) mains_pulse();
        pins(4'h0);
        mains_pulse();
        pins(4'hE);
        reset_pin(1'b1);
        reset_pin(1'b0);
        bus(1'b1, rsm_pkg::CTRL_OFS, 32'h1);
        repeat (3) @(posedge clk);
        rd(rsm_pkg::STATUS_OFS, 32'h00000080, 32'h0000E0E0);
        reset_pin(1'b0);
        pins(4'hC);
        bus(1'b1, rsm_pkg::CTRL_OFS, 32'h10);
        reset_pin(1'b0);
        pins(4'h0);
        i_rsm_cpu_model.set_lines(4'h0, 4'h1);
        i_rsm_cpu_model.enable_pulse(0);
        i_rsm_cpu_model.set_lines(4'h2, 4'h1);
        repeat (20) @(posedge clk);
        i_rsm_cpu_model.set_lines(4'h0, 4'h1);
        repeat (10) @(posedge clk);
        pins(4'hC);
        conclude();
    end
endmodule
